/* src/crc_unit_pkg.sv */
/*
  Shared constants of the byte stream CRC engine: polynomials, preset values,
  widths, control encodings and reset values.
  Assumes nothing of its surroundings beyond a SystemVerilog compiler.
*/
`default_nettype none

package crc_unit_pkg;

  // Width of one input byte and of one result lane.
  localparam int unsigned BYTE_W        = 8;
  // Number of bit steps applied for every input byte.
  localparam int unsigned BIT_STEPS     = 8;
  // Width of the internal result register.
  localparam int unsigned RESULT_W      = 32;
  // Width of the result byte pointer.
  localparam int unsigned PTR_W         = 2;

  // Generator polynomial for the 16-bit width, processed MSB first.
  localparam logic [15:0] POLY16        = 16'h1021;
  // Normal form of the 32-bit polynomial, kept for reference.
  localparam logic [31:0] POLY32        = 32'h04C1_1DB7;
  // Reflected form of the 32-bit polynomial, used by the engine.
  localparam logic [31:0] POLY32_REFL   = 32'hEDB8_8320;

  // Preset values chosen by the preset value select control.
  localparam logic [31:0] PRESET_ZEROS  = 32'h0000_0000;
  localparam logic [31:0] PRESET_ONES   = 32'hFFFF_FFFF;

  // Encodings of the polynomial width select control.
  localparam logic        SEL_WIDTH_32  = 1'b0;
  localparam logic        SEL_WIDTH_16  = 1'b1;

  // Reset values of the block's state.
  localparam logic [31:0] RESULT_RESET  = 32'h0000_0000;
  localparam logic [1:0]  PTR_RESET     = 2'h0;
  localparam logic [7:0]  RDATA_RESET   = 8'h00;

endpackage

`default_nettype wire

/* src/byte_stream_crc_engine.sv */
/*
  Byte stream CRC engine. Software writes bytes to the input strobe and the
  internal result updates in the same cycle, in 16-bit MSB-first or 32-bit
  reflected form. The result is reached only through a byte pointer and a
  result data port, which read and write one byte at a time.
  All eight bit steps are unrolled into one combinational path, which trades
  a longer path for zero latency: a byte taken on one edge is folded in before
  the next edge, so back to back byte writes never need a busy flag.
  Assumes all control strobes come from logic on i_mclk and last one cycle.
*/
// Contract
// - Accept bytes, compute 16 or 32 bit CRC.
// - Result reached only via pointer and data port.
// - 16-bit mode is MSB first, poly 0x1021.
// - 16-bit: byte XORs into upper result byte.
// - 16-bit first byte starts from preset value.
// - 16-bit: shift left, XOR poly if MSB set.
// - Exactly eight bit steps per input byte.
// - 32-bit mode uses reflected poly 0x04C11DB7.
// - 32-bit: byte XORs into lowest result byte.
// - 32-bit first byte starts from preset value.
// - 32-bit: test LSB, shift right, XOR 0xEDB88320.
// - 16-bit known answers 0xBD35 and 0x6CF6.
// - 32-bit known answers 0xF9462090 and 0x41B207B3.
// - Select zero means 32-bit, one means 16-bit.
// - Preset trigger loads all zeros or ones.
// - Result updates on each byte, no start.
// - Pointer picks byte, increments per access.
`timescale 1ns/1ns
`default_nettype none

module byte_stream_crc_engine (
  // Clock, reset and clock enable.
  input  wire logic                             i_mclk,
  input  wire logic                             i_rst,
  input  wire logic                             i_ce,
  // Configuration levels.
  input  wire logic                             i_poly_width_select,
  input  wire logic                             i_preset_value_select,
  // Preset strobe.
  input  wire logic                             i_result_preset_trigger,
  // Byte input strobe and data.
  input  wire logic                             i_crc_byte_input_wr,
  input  wire logic [crc_unit_pkg::BYTE_W-1:0]  i_crc_byte_input,
  // Pointer write strobe and value.
  input  wire logic                             i_result_byte_pointer_wr,
  input  wire logic [crc_unit_pkg::PTR_W-1:0]   i_result_byte_pointer,
  // Result data port strobes and write data.
  input  wire logic                             i_result_data_port_rd,
  input  wire logic                             i_result_data_port_wr,
  input  wire logic [crc_unit_pkg::BYTE_W-1:0]  i_result_data_port_wdata,
  // Read back of pointer and data port.
  output logic      [crc_unit_pkg::PTR_W-1:0]   o_result_byte_pointer,
  output logic      [crc_unit_pkg::BYTE_W-1:0]  o_result_data_port_rdata
);
  import crc_unit_pkg::*;

  // Internal result register, never driven onto a port directly.
  logic [RESULT_W-1:0] crc_result;
  // Byte pointer for the result data port.
  logic [PTR_W-1:0]    result_ptr;
  // Registered read data of the result data port.
  logic [BYTE_W-1:0]   rdata;
  // Result after applying the current input byte.
  logic [RESULT_W-1:0] next_crc;
  // Lane index that the pointer selects for the current width.
  logic [PTR_W-1:0]    lane;
  // Byte currently seen through the result data port.
  logic [BYTE_W-1:0]   lane_byte;
  // Result after a data port write into the selected lane.
  logic [RESULT_W-1:0] next_lane_write;

  // One full byte update, all eight bit steps unrolled in one cycle.
  function automatic logic [RESULT_W-1:0] crc_byte_update(
    input logic [RESULT_W-1:0] acc_in,
    input logic [BYTE_W-1:0]   din,
    input logic                width_sel
  );
    logic [RESULT_W-1:0] acc;
    acc = acc_in;
    if (width_sel == SEL_WIDTH_16) begin
      // Byte enters the top of the 16-bit result.
      acc[15:8] = acc[15:8] ^ din;
      for (int i = 0; i < BIT_STEPS; i++) begin
        // MSB first: shift left, fold in the polynomial on a carry out.
        if (acc[15]) begin
          acc[15:0] = {acc[14:0], 1'b0} ^ POLY16;
        end else begin
          acc[15:0] = {acc[14:0], 1'b0};
        end
      end
    end else begin
      // Byte enters the bottom of the 32-bit result.
      acc[7:0] = acc[7:0] ^ din;
      for (int i = 0; i < BIT_STEPS; i++) begin
        // Reflected form: test LSB, shift right, fold in the polynomial.
        if (acc[0]) begin
          acc = {1'b0, acc[RESULT_W-1:1]} ^ POLY32_REFL;
        end else begin
          acc = {1'b0, acc[RESULT_W-1:1]};
        end
      end
    end
    return acc;
  endfunction

  // Byte update of the running result; the preset value is simply the
  // result left by the preset strobe, so the first byte starts from it.
  always_comb begin
    next_crc = crc_byte_update(crc_result, i_crc_byte_input,
                               i_poly_width_select);
  end

  // Lane selection: in 16-bit mode the upper pointer bit is ignored, so
  // pointer values 2 and 3 repeat the low and high bytes.
  always_comb begin
    if (i_poly_width_select == SEL_WIDTH_16) begin
      lane = {1'b0, result_ptr[0]};
    end else begin
      lane = result_ptr;
    end
  end

  // Byte visible through the data port and the result after a lane write.
  always_comb begin
    lane_byte       = crc_result[lane*BYTE_W +: BYTE_W];
    next_lane_write = crc_result;
    next_lane_write[lane*BYTE_W +: BYTE_W] = i_result_data_port_wdata;
  end

  // Result register. The preset strobe wins over a byte in the same cycle,
  // and a byte wins over a data port write.
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      crc_result <= RESULT_RESET;
    end else if (i_ce) begin
      if (i_result_preset_trigger) begin
        // Whole result loads the chosen preset in either width.
        crc_result <= i_preset_value_select ? PRESET_ONES
                                            : PRESET_ZEROS;
      end else if (i_crc_byte_input_wr) begin
        // Update completes in this cycle, so the next write sees it.
        crc_result <= next_crc;
      end else if (i_result_data_port_wr) begin
        // Software overwrites the selected result byte.
        crc_result <= next_lane_write;
      end
    end
  end

  // Pointer register. A direct pointer write wins over auto increment.
  // A data port access in the same cycle as a pointer write leaves no step.
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      result_ptr <= PTR_RESET;
    end else if (i_ce) begin
      if (i_result_byte_pointer_wr) begin
        // Software places the pointer.
        result_ptr <= i_result_byte_pointer;
      end else if (i_result_data_port_rd || i_result_data_port_wr) begin
        // Every data port access moves to the next byte, wrapping at 3.
        result_ptr <= result_ptr + 2'd1;
      end
    end
  end

  // Read data register, loaded with the selected byte on each read.
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      rdata <= RDATA_RESET;
    end else if (i_ce) begin
      if (i_result_data_port_rd) begin
        // Byte as it stood before any update in the same cycle.
        rdata <= lane_byte;
      end
    end
  end

  // Outputs come straight from the registers.
  assign o_result_byte_pointer    = result_ptr;
  assign o_result_data_port_rdata = rdata;

  // Checks on the engine's own behaviour.
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_rst);

  // Preset strobe loads the chosen value one cycle later.
  a_preset_load_value: assert property (
    i_ce && i_result_preset_trigger
    |=> crc_result == ($past(i_preset_value_select) ? PRESET_ONES
                                                    : PRESET_ZEROS))
    else $error("preset strobe did not load the chosen value");

  // 16-bit known answer for the single byte 0x63 from all ones.
  a_crc16_known_answer: assert property (
    i_ce && !i_result_preset_trigger && i_crc_byte_input_wr
    && i_poly_width_select == SEL_WIDTH_16
    && crc_result[15:0] == 16'hFFFF && i_crc_byte_input == 8'h63
    |=> crc_result[15:0] == 16'hBD35)
    else $error("16-bit result for byte 0x63 is wrong");

  // 32-bit known answer for the single byte 0x63 from all ones.
  a_crc32_known_answer: assert property (
    i_ce && !i_result_preset_trigger && i_crc_byte_input_wr
    && i_poly_width_select == SEL_WIDTH_32
    && crc_result == PRESET_ONES && i_crc_byte_input == 8'h63
    |=> crc_result == 32'hF946_2090)
    else $error("32-bit result for byte 0x63 is wrong");

  // 16-bit updates leave the unused upper half untouched.
  a_upper_half_hold: assert property (
    i_ce && !i_result_preset_trigger && i_crc_byte_input_wr
    && i_poly_width_select == SEL_WIDTH_16
    |=> crc_result[31:16] == $past(crc_result[31:16]))
    else $error("16-bit update disturbed the upper half");

  // Each data port access without a pointer write advances the pointer by one.
  a_pointer_advance: assert property (
    i_ce && !i_result_byte_pointer_wr
    && (i_result_data_port_rd || i_result_data_port_wr)
    |=> result_ptr == $past(result_ptr) + 2'd1)
    else $error("pointer did not advance after a data port access");

  // In 16-bit mode pointer 2 reads the low byte again.
  a_read_repeat_low: assert property (
    i_ce && i_result_data_port_rd && result_ptr == 2'd2
    && i_poly_width_select == SEL_WIDTH_16
    |=> o_result_data_port_rdata == $past(crc_result[7:0]))
    else $error("16-bit pointer 2 did not read the low byte");

  // In 32-bit mode pointer 3 reads the top byte.
  a_read_top_byte: assert property (
    i_ce && i_result_data_port_rd && result_ptr == 2'd3
    && i_poly_width_select == SEL_WIDTH_32
    |=> o_result_data_port_rdata == $past(crc_result[31:24]))
    else $error("32-bit pointer 3 did not read the top byte");

  // A byte of zero into a zero 32-bit result keeps it zero, checked in the
  // cycle after the single byte strobe.
  a_zero_byte_zero: assert property (
    i_ce && !i_result_preset_trigger && i_crc_byte_input_wr
    && i_poly_width_select == SEL_WIDTH_32
    && crc_result == PRESET_ZEROS && i_crc_byte_input == 8'h00
    |=> crc_result == PRESET_ZEROS)
    else $error("zero byte changed a zero 32-bit result");

  // Clock enable low freezes all state.
  a_enable_freeze: assert property (
    !i_ce |=> $stable(crc_result) && $stable(result_ptr) && $stable(rdata))
    else $error("state changed while clock enable was low");

  // A pointer write places the pointer, whatever else happens.
  a_pointer_load: assert property (
    i_ce && i_result_byte_pointer_wr
    |=> result_ptr == $past(i_result_byte_pointer))
    else $error("pointer write did not load the pointer");

  // In 16-bit mode pointer 3 reads the high byte again.
  a_read_repeat_high: assert property (
    i_ce && i_result_data_port_rd && result_ptr == 2'd3
    && i_poly_width_select == SEL_WIDTH_16
    |=> o_result_data_port_rdata == $past(crc_result[15:8]))
    else $error("16-bit pointer 3 did not read the high byte");

  // A lone 32-bit data port write lands in the byte the pointer names.
  a_lane_write_land: assert property (
    i_ce && i_result_data_port_wr && !i_result_preset_trigger && !i_crc_byte_input_wr
    && i_poly_width_select == SEL_WIDTH_32
    |=> crc_result[$past(result_ptr)*BYTE_W +: BYTE_W] == $past(i_result_data_port_wdata))
    else $error("data port write missed the selected result byte");

  // Read data stands until the next read is taken.
  a_rdata_hold: assert property (
    i_ce && !i_result_data_port_rd
    |=> $stable(o_result_data_port_rdata))
    else $error("read data changed without a read");

  // With no preset, byte or data port write the result stays put.
  a_result_hold_idle: assert property (
    i_ce && !i_result_preset_trigger && !i_crc_byte_input_wr
    && !i_result_data_port_wr
    |=> $stable(crc_result))
    else $error("result changed with no update request");

  // A preset followed by a byte in each width.
  c_preset_then_byte16: cover property (
    i_ce && i_result_preset_trigger && i_poly_width_select
    ##1 i_ce && i_crc_byte_input_wr);
  c_preset_then_byte32: cover property (
    i_ce && i_result_preset_trigger && !i_poly_width_select
    ##1 i_ce && i_crc_byte_input_wr);
  // Back to back input bytes.
  c_back_to_back_bytes: cover property (
    i_ce && i_crc_byte_input_wr ##1 i_ce && i_crc_byte_input_wr);
  // Pointer wraps from 3 to 0 on a read.
  c_pointer_wrap: cover property (
    i_ce && i_result_data_port_rd && result_ptr == 2'd3);
  // Software overwrites the top result byte.
  c_lane_write: cover property (
    i_ce && i_result_data_port_wr && result_ptr == 2'd3);

endmodule

`default_nettype wire

/* tb/cpu_model.sv */
/*
  Processor side model: it drives the CRC engine's levels and strobes the way
  software would, one register access per clock.
  Assumes one rising-edge clock shared with the engine and no wait states.
*/
`timescale 1ns/1ns
`default_nettype none

module cpu_model (
  // Clock.
  input  wire logic       i_mclk,
  // Levels toward the engine.
  output var  logic       o_ce,
  output var  logic       o_sel,
  output var  logic       o_val,
  // Strobes and data toward the engine.
  output var  logic       o_preset,
  output var  logic       o_byte_wr,
  output var  logic [7:0] o_byte,
  output var  logic       o_ptr_wr,
  output var  logic [1:0] o_ptr,
  output var  logic       o_rd,
  output var  logic       o_wr,
  output var  logic [7:0] o_wdata
);

  // Everything idle at time zero, with the clock enable on.
  initial begin
    {o_sel, o_val, o_preset, o_byte_wr, o_ptr_wr, o_rd, o_wr} = 7'h00;
    {o_byte, o_wdata, o_ptr} = 18'h0_0000;
    o_ce = 1'b1;
  end

  // Width and preset are chosen before the preset strobe is taken.
  task automatic setup(input logic sel, input logic val);
    @(posedge i_mclk);
    o_sel    <= sel;
    o_val    <= val;
    o_preset <= 1'b1;
    @(posedge i_mclk);
    o_preset <= 1'b0;
  endtask

  // Streams bytes back to back, one per clock.
  task automatic send(input logic [7:0] b[$]);
    foreach (b[i]) begin
      @(posedge i_mclk);
      o_byte_wr <= 1'b1;
      o_byte    <= b[i];
    end
    @(posedge i_mclk);
    o_byte_wr <= 1'b0;
    o_byte    <= ~o_byte;  // Stale data never looks valid.
  endtask

  // Loads the result byte pointer.
  task automatic point(input logic [1:0] p);
    @(posedge i_mclk);
    o_ptr_wr <= 1'b1;
    o_ptr    <= p;
    @(posedge i_mclk);
    o_ptr_wr <= 1'b0;
  endtask

  // Four back to back reads of the data port.
  task automatic read_n();
    repeat (4) begin
      @(posedge i_mclk);
      o_rd <= 1'b1;
    end
    @(posedge i_mclk);
    o_rd <= 1'b0;
  endtask

  // Four back to back writes of the data port, low byte first.
  task automatic write_n(input logic [31:0] d);
    for (int k = 0; k < 4; k++) begin
      @(posedge i_mclk);
      o_wr    <= 1'b1;
      o_wdata <= d[8*k +: 8];
    end
    @(posedge i_mclk);
    o_wr <= 1'b0;
  endtask

  // Changes the clock enable level.
  task automatic set_ce(input logic v);
    @(posedge i_mclk);
    o_ce <= v;
  endtask

endmodule

`default_nettype wire

/* tb/testbench.sv */
/*
  Self-checking bench for the byte stream CRC engine.
  Assumes the package under src and the processor model in cpu_model.sv.
*/
`timescale 1ns/1ns
`default_nettype none

module testbench;
  import crc_unit_pkg::*;

  logic        i_mclk = 1'b0;  // System clock.
  logic        i_rst  = 1'b1;  // Reset, held at the start.
  logic        ce, sel, val, pre, bwr, pwr, rd, dwr;
  logic [7:0]  bdat, wdat, rdata;
  logic [1:0]  pdat, ptr;
  logic [7:0]  exp_q[$];       // Expected read bytes, oldest first.
  logic        rd_seen = 1'b0; // A read was taken at the last edge.
  int          n_errors = 0;
  int          check_count = 0;
  int          seed = 32'h2a8b;
  logic [31:0] acc;            // Reference result.
  logic [7:0]  bytes[$];       // Byte stream under test.
  logic [31:0] known[2][3] = '{'{32'hF946_2090, 32'h41B2_07B3, 32'h78D1_29BC},
                               '{32'h0000_BD35, 32'h0000_6CF6, 32'h0000_B166}};

  always #5 i_mclk = ~i_mclk;

  cpu_model i_cpu_model (.i_mclk(i_mclk), .o_ce(ce), .o_sel(sel), .o_val(val), .o_preset(pre),
    .o_byte_wr(bwr), .o_byte(bdat), .o_ptr_wr(pwr), .o_ptr(pdat), .o_rd(rd), .o_wr(dwr), .o_wdata(wdat));

  byte_stream_crc_engine i_byte_stream_crc_engine (.i_mclk(i_mclk), .i_rst(i_rst), .i_ce(ce),
    .i_poly_width_select(sel), .i_preset_value_select(val), .i_result_preset_trigger(pre),
    .i_crc_byte_input_wr(bwr), .i_crc_byte_input(bdat), .i_result_byte_pointer_wr(pwr),
    .i_result_byte_pointer(pdat), .i_result_data_port_rd(rd), .i_result_data_port_wr(dwr),
    .i_result_data_port_wdata(wdat), .o_result_byte_pointer(ptr), .o_result_data_port_rdata(rdata));

  // Counts a comparison and reports it when the values differ.
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Software reference of one byte update in either width.
  function automatic logic [31:0] step(logic [31:0] a, logic [7:0] b, logic w16);
    if (w16) begin
      a[15:8] = a[15:8] ^ b;
      for (int i = 0; i < 8; i++) a[15:0] = {a[14:0], 1'b0} ^ (a[15] ? POLY16 : 16'h0000);
    end else begin
      a[7:0] = a[7:0] ^ b;
      for (int i = 0; i < 8; i++) a = (a >> 1) ^ (a[0] ? POLY32_REFL : 32'h0000_0000);
    end
    return a;
  endfunction

  // Notes the bytes due from pointer p, reads four, then checks the wrap.
  task automatic readback(input logic [31:0] r, input logic w16, input logic [1:0] p);
    for (int k = 0; k < 4; k++) begin
      exp_q.push_back(r[8*(w16 ? (int'(p[0]) + k) % 2 : (int'(p) + k) % 4) +: 8]);
    end
    i_cpu_model.point(p);
    i_cpu_model.read_n();
    @(posedge i_mclk);
    check("pointer", 32'(ptr), 32'(p));
  endtask

  // Compares each byte read with the oldest note once the read has landed.
  always @(posedge i_mclk) begin
    if (rd_seen) check("rdata", 32'(rdata), 32'(exp_q.pop_front()));
    rd_seen <= rd & ce;
  end

  // Prints the verdict and ends the run.
  task automatic close_out();
    if (n_errors == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // Cuts a hang short well after the sequence should have ended.
  initial begin
    repeat (3000) @(posedge i_mclk);
    n_errors++;
    close_out();
  end

  // Main sequence.
  initial begin
    repeat (10) @(posedge i_mclk);
    i_rst <= 1'b0;
    @(posedge i_mclk);
    check("ptr_reset", 32'(ptr), 32'h0000_0000);
    check("rdata_reset", 32'(rdata), 32'h0000_0000);
    // Known answers from an all-ones preset in both widths.
    for (int w = 0; w < 2; w++) begin
      for (int v = 0; v < 3; v++) begin
        bytes.delete();
        if (v == 2) bytes = {8'h00, 8'h00};
        if (v == 0) bytes.push_back(8'h63);
        else bytes = {bytes, 8'hAA, 8'hBB, 8'hCC};
        i_cpu_model.setup(w[0], 1'b1);
        i_cpu_model.send(bytes);
        readback(known[w][v], w[0], 2'h0);
      end
    end
    // Random streams from an all-zeros preset, read from pointer one.
    for (int w = 0; w < 2; w++) begin
      acc = PRESET_ZEROS;
      bytes.delete();
      for (int i = 0; i < 6; i++) begin
        // A leading zero byte keeps a zero 32-bit result at zero.
        bytes.push_back(i == 0 ? 8'h00 : 8'($random(seed)));
        acc = step(acc, bytes[i], w[0]);
      end
      i_cpu_model.setup(w[0], 1'b0);
      i_cpu_model.send(bytes);
      readback(acc, w[0], 2'h1);
    end
    // Overwrite the result through the data port, then feed one byte on top.
    i_cpu_model.setup(SEL_WIDTH_32, 1'b0);
    acc = $random(seed);
    i_cpu_model.point(2'h0);
    i_cpu_model.write_n(acc);
    acc = step(acc, 8'h5A, SEL_WIDTH_32);
    bytes = {8'h5A};
    i_cpu_model.send(bytes);
    readback(acc, SEL_WIDTH_32, 2'h2);
    // With the clock enable low, a byte strobe must leave the result alone.
    i_cpu_model.set_ce(1'b0);
    i_cpu_model.send(bytes);
    i_cpu_model.set_ce(1'b1);
    readback(acc, SEL_WIDTH_32, 2'h3);
    // A preset alone loads every bit of the result.
    i_cpu_model.setup(SEL_WIDTH_32, 1'b1);
    readback(PRESET_ONES, SEL_WIDTH_32, 2'h0);
    repeat (3) @(posedge i_mclk);
    close_out();
  end

endmodule

`default_nettype wire
